// [sbp_bus_partner.sv]
// sbp_bus_partner.sv: host and neighbour modules on the sensor bus
// assumes pin bits ordered tx drive, tx relay, rx relay, rx bus
`timescale 1ns/1ps
`default_nettype none
module sbp_bus_partner (
    input wire logic       sys_clk,
    input wire logic [3:0] pin_o, pin_oe,
    output wire logic [3:0] pin_i
);
    logic [3:0] far_r = 4'h5;
    // host ids and commands, downstream traffic; never idle-constant
    always @(posedge sys_clk) far_r <= ~far_r ^ {3'h0, far_r[3]};
    // relay lines pulled up by the transistors when released
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & {far_r[3], 2'b11, far_r[0]});
endmodule
`default_nettype wire

// [sbp_defs.vh]
// sbp_defs.vh: register map, field positions, reset values and timing for the sensor bus path unit
// assumes inclusion by bare name from the design files
`ifndef SBP_DEFS_VH
`define SBP_DEFS_VH

// register byte addresses on the wishbone slave
`define SBP_ADR_CTRL        4'h0
`define SBP_ADR_PORT_OUT    4'h4
`define SBP_ADR_PORT_OE     4'h8
`define SBP_ADR_STATUS      4'hc
`define SBP_ADR_W           4

// control register fields
`define SBP_BIT_TX_RELAY_SEL  0
`define SBP_BIT_RX_RELAY_SEL  1
`define SBP_BIT_PASS_EN       2
`define SBP_BIT_DIR_SEL       3
`define SBP_CTRL_W            4
`define SBP_CTRL_RST          4'h0

// general port latch fields, one bit per pin
`define SBP_PIN_TX_DRIVE    0
`define SBP_PIN_TX_RELAY    1
`define SBP_PIN_RX_RELAY    2
`define SBP_PIN_RX_BUS      3
`define SBP_PINS            4
`define SBP_PORT_RST        4'h0

// status register fields
`define SBP_ST_PIN_LO       0
`define SBP_ST_RX_PATH      4
`define SBP_ST_TX_PATH      5
`define SBP_ST_PASS_PATH    6
`define SBP_ST_SCHEME_CLASH 7

`define SBP_DATA_W          32
`define SBP_ACK_CYCLES      1

`endif

// [sbp_path_ctrl.v]
// sbp_path_ctrl.v: sensor bus path control unit, top level
// Function
// (R1) direction select 0 offers receive relay path, 1 offers transmit relay path.
// (R2) pass path enable 1 joins rx bus pin and tx drive pin.
// (R3) receive relay select 1 with direction 0 drives rx relay pin from rx bus.
// (R4) transmit relay select 1 with direction 1 drives tx relay pin from tx drive.
// (R5) control bits reset to zero; upper unimplemented bits read zero.
// (R6) in 12V scheme firmware keeps pass path enable cleared.
// (R7) in 5V scheme firmware keeps direction and both relay selects zero.
// (R8) unaddressed 12V module: dir 0, tx relay 0, rx relay 1, request on tx relay.
// (R9) 12V module with ID sets direction and transmit relay select to 1.
// (R10) 12V match clears dir and tx relay to reply; mismatch sets both.
// (R11) 12V after response: direction 0, receive relay 1, wait.
// (R12) unaddressed 5V module clears pass enable, drives request on rx bus pin.
// (R13) 5V module with ID sets pass enable, chaining to next module.
// (R14) 5V matched module keeps pass enable 1 and replies on rx bus pin.
// (R15) host assigns unique IDs then broadcasts commands to all modules.
// (R16) paths are combinational from register bits; disabled pins revert to port control.
// assumes a classic wishbone master on sys_clk and pin pads outside
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defs.vh"

module sbp_path_ctrl (
    // clock and reset
    input  wire                   sys_clk,
    input  wire                   rst,
    // wishbone slave
    input  wire                   wb_cyc_i,
    input  wire                   wb_stb_i,
    input  wire                   wb_we_i,
    input  wire [31:0]            wb_adr_i,
    input  wire [3:0]             wb_sel_i,
    input  wire [31:0]            wb_dat_i,
    output reg  [31:0]            wb_dat_o,
    output wire                   wb_ack_o,
    // tx drive pin
    input  wire                   tx_drive_pin_i,
    output wire                   tx_drive_pin_o,
    output wire                   tx_drive_pin_oe,
    // tx relay pin
    input  wire                   tx_relay_pin_i,
    output wire                   tx_relay_pin_o,
    output wire                   tx_relay_pin_oe,
    // rx relay pin
    input  wire                   rx_relay_pin_i,
    output wire                   rx_relay_pin_o,
    output wire                   rx_relay_pin_oe,
    // rx bus pin
    input  wire                   rx_bus_pin_i,
    output wire                   rx_bus_pin_o,
    output wire                   rx_bus_pin_oe
);

    // control, port latch and direction registers
    reg  [`SBP_CTRL_W-1:0]  ctrl_r;
    reg  [`SBP_PINS-1:0]    port_out_r;
    reg  [`SBP_PINS-1:0]    port_oe_r;
    reg  [31:0]             rd_nxt;
    wire                    wr_go;
    wire                    rd_go;
    wire [`SBP_ADR_W-1:0]   adr;

    wire dir_sel;
    wire pass_en;
    wire rx_relay_sel;
    wire tx_relay_sel;
    wire rx_path_on;
    wire tx_path_on;
    wire scheme_clash;
    wire [`SBP_PINS-1:0] pin_in;

    assign adr = wb_adr_i[`SBP_ADR_W-1:0];

    sbp_wb_slave u_wb (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_ack_o (wb_ack_o),
        .wr_go    (wr_go),
        .rd_go    (rd_go)
    );

    // register writes; only lane 0 carries data
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r     <= `SBP_CTRL_RST; // see (R5)
            port_out_r <= `SBP_PORT_RST;
            port_oe_r  <= `SBP_PORT_RST;
        end else if (wr_go && wb_sel_i[0]) begin
            case (adr)
                `SBP_ADR_CTRL: begin
                    // firmware sequences of (R8) to (R14) land here
                    ctrl_r <= wb_dat_i[`SBP_CTRL_W-1:0]; // see (R9)
                end
                `SBP_ADR_PORT_OUT: begin
                    port_out_r <= wb_dat_i[`SBP_PINS-1:0];
                end
                `SBP_ADR_PORT_OE: begin
                    port_oe_r <= wb_dat_i[`SBP_PINS-1:0]; // see (R12)
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    assign dir_sel      = ctrl_r[`SBP_BIT_DIR_SEL];
    assign pass_en      = ctrl_r[`SBP_BIT_PASS_EN];
    assign rx_relay_sel = ctrl_r[`SBP_BIT_RX_RELAY_SEL];
    assign tx_relay_sel = ctrl_r[`SBP_BIT_TX_RELAY_SEL];

    // relay path gating by direction select
    assign rx_path_on = rx_relay_sel & ~dir_sel; // see (R1) see (R3) see (R11)
    assign tx_path_on = tx_relay_sel &  dir_sel; // see (R1) see (R4) see (R10)

    // both scheme bit groups set at once; firmware should avoid this
    assign scheme_clash = pass_en & (dir_sel | rx_relay_sel | tx_relay_sel); // see (R6) see (R7)

    assign pin_in = {rx_bus_pin_i, rx_relay_pin_i, tx_relay_pin_i, tx_drive_pin_i};

    // read mux, unimplemented bits zero
    always @* begin
        rd_nxt = 32'h0;
        case (adr)
            `SBP_ADR_CTRL:     rd_nxt[`SBP_CTRL_W-1:0] = ctrl_r; // see (R5)
            `SBP_ADR_PORT_OUT: rd_nxt[`SBP_PINS-1:0]   = port_out_r;
            `SBP_ADR_PORT_OE:  rd_nxt[`SBP_PINS-1:0]   = port_oe_r;
            `SBP_ADR_STATUS: begin
                rd_nxt[`SBP_PINS-1:0]        = pin_in;
                rd_nxt[`SBP_ST_RX_PATH]      = rx_path_on;
                rd_nxt[`SBP_ST_TX_PATH]      = tx_path_on;
                rd_nxt[`SBP_ST_PASS_PATH]    = pass_en;
                rd_nxt[`SBP_ST_SCHEME_CLASH] = scheme_clash;
            end
            default:           rd_nxt = 32'h0;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (rd_go) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // pass path: tx drive pin follows rx bus pin while enabled, else port latch
    sbp_pin_cell u_tx_drive (
        .path_sel (pass_en), // see (R2) see (R13) see (R14)
        .path_out (rx_bus_pin_i),
        .path_oe  (1'b1),
        .gpio_out (port_out_r[`SBP_PIN_TX_DRIVE]),
        .gpio_oe  (port_oe_r[`SBP_PIN_TX_DRIVE]),
        .pin_o    (tx_drive_pin_o),
        .pin_oe   (tx_drive_pin_oe)
    );

    // rx bus pin stays port controlled; the chain drives tx drive from it
    sbp_pin_cell u_rx_bus (
        .path_sel (1'b0),
        .path_out (1'b0),
        .path_oe  (1'b0),
        .gpio_out (port_out_r[`SBP_PIN_RX_BUS]),
        .gpio_oe  (port_oe_r[`SBP_PIN_RX_BUS]), // see (R12) see (R14)
        .pin_o    (rx_bus_pin_o),
        .pin_oe   (rx_bus_pin_oe)
    );

    // transmit relay: tx relay pin follows tx drive pin
    sbp_pin_cell u_tx_relay (
        .path_sel (tx_path_on), // see (R16)
        .path_out (tx_drive_pin_i),
        .path_oe  (1'b1),
        .gpio_out (port_out_r[`SBP_PIN_TX_RELAY]),
        .gpio_oe  (port_oe_r[`SBP_PIN_TX_RELAY]), // see (R8)
        .pin_o    (tx_relay_pin_o),
        .pin_oe   (tx_relay_pin_oe)
    );

    // receive relay: rx relay pin follows rx bus pin
    sbp_pin_cell u_rx_relay (
        .path_sel (rx_path_on), // see (R16)
        .path_out (rx_bus_pin_i),
        .path_oe  (1'b1),
        .gpio_out (port_out_r[`SBP_PIN_RX_RELAY]),
        .gpio_oe  (port_oe_r[`SBP_PIN_RX_RELAY]),
        .pin_o    (rx_relay_pin_o),
        .pin_oe   (rx_relay_pin_oe)
    );

endmodule

`default_nettype wire

// [sbp_path_ctrl_assertions.sv]
// sbp_path_ctrl_assertions.sv: port checks for the sensor bus path unit
// assumes bind onto sbp_path_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sbp_path_ctrl_assertions (
    // clock, reset and bus
    input wire logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
    input wire logic [3:0]  wb_sel_i,
    // pins
    input wire logic        tx_drive_pin_i, tx_drive_pin_o, tx_drive_pin_oe,
    input wire logic        tx_relay_pin_i, tx_relay_pin_o, tx_relay_pin_oe,
    input wire logic        rx_relay_pin_i, rx_relay_pin_o, rx_relay_pin_oe,
    input wire logic        rx_bus_pin_i, rx_bus_pin_o, rx_bus_pin_oe
);
    logic [3:0] ctl_r, oe_r;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rxp = ctl_r[1] && !ctl_r[3];
    wire txp = ctl_r[0] && ctl_r[3];
    // shadow of the control and port enable registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_r <= 4'h0;
            oe_r <= 4'h0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i[3:0] == 4'h0) ctl_r <= wb_dat_i[3:0];
            if (wb_adr_i[3:0] == 4'h8) oe_r <= wb_dat_i[3:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ctrl_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:0] == 4'h0
        |-> wb_dat_o == {28'h0, ctl_r}) else $error("ctrl read wrong");
    a_rx_relay: assert property (rxp |-> rx_relay_pin_oe && rx_relay_pin_o == rx_bus_pin_i)
        else $error("rx relay path wrong");
    a_tx_relay: assert property (txp |-> tx_relay_pin_oe && tx_relay_pin_o == tx_drive_pin_i)
        else $error("tx relay path wrong");
    a_pass_path: assert property (ctl_r[2] |-> tx_drive_pin_oe && tx_drive_pin_o == rx_bus_pin_i)
        else $error("pass path wrong");
    a_rx_fallback: assert property (!rxp |-> rx_relay_pin_oe == oe_r[2])
        else $error("rx relay not released");
    a_tx_fallback: assert property (!txp |-> tx_relay_pin_oe == oe_r[1])
        else $error("tx relay not released");
    a_bus_pin_port: assert property (rx_bus_pin_oe == oe_r[3]) else $error("bus pin enable");
    cover property (rxp);
    cover property (txp);
    cover property (ctl_r[2] && rx_bus_pin_oe);
endmodule
`default_nettype wire

// [sbp_path_ctrl_tb.sv]
// sbp_path_ctrl_tb.sv: self-checking bench for the sensor bus path unit
// assumes the design files and the partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
module sbp_path_ctrl_tb;
    logic        sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [31:0] adr = 0, wdat = 0, rd;
    logic [3:0]  c = 0, lo = 0, le = 0, sel = 4'hf, wsel = 4'hf;
    wire  [31:0] dat_o;
    wire  [3:0]  po, poe, pi;
    wire         ack;
    int          failures = 0, num_checks = 0;
    sbp_path_ctrl sbp_path_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack),
        .tx_drive_pin_i(pi[0]), .tx_drive_pin_o(po[0]), .tx_drive_pin_oe(poe[0]),
        .tx_relay_pin_i(pi[1]), .tx_relay_pin_o(po[1]), .tx_relay_pin_oe(poe[1]),
        .rx_relay_pin_i(pi[2]), .rx_relay_pin_o(po[2]), .rx_relay_pin_oe(poe[2]),
        .rx_bus_pin_i(pi[3]), .rx_bus_pin_o(po[3]), .rx_bus_pin_oe(poe[3]));
    sbp_bus_partner sbp_bus_partner_inst (.sys_clk(sys_clk), .pin_o(po), .pin_oe(poe),
        .pin_i(pi));
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge sys_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge sys_clk);
        if (n == 20) begin
            failures++;
            finish_test();
        end
        rd = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1, {28'h0, a}, d);
        if (a == 4'h0) c = d[3:0];
        if (a == 4'h4) lo = d[3:0];
        if (a == 4'h8) le = d[3:0];
    endtask
    // expected pin drive from control bits and port latches
    task automatic pins;
        logic [3:0] eo, ee;
        repeat (3) begin
            @(posedge sys_clk);
            ee = le;
            eo = lo;
            if (c[2]) begin ee[0] = 1; eo[0] = pi[3]; end
            if (c[0] & c[3]) begin ee[1] = 1; eo[1] = pi[0]; end
            if (c[1] & ~c[3]) begin ee[2] = 1; eo[2] = pi[3]; end
            chk({poe, po}, {ee, eo});
        end
    endtask
    task automatic t_reset;
        bus(0, 0, 0);
        chk(rd, 0);
        pins();
    endtask
    task automatic t_regs;
        wr(0, 32'hffffff0f);
        bus(0, 0, 0);
        chk(rd, 32'h0000000f);
        bus(0, 3, 0);
        chk(rd, 0);
        // lane 0 not selected: control write must be ignored
        wsel = 4'he;
        bus(1, 0, 5);
        wsel = 4'hf;
        bus(0, 0, 0);
        chk(rd, 32'h0000000f);
    endtask
    task automatic t_12v;
        wr(8, 2);
        wr(4, 2);
        wr(0, 2);
        pins();
        wr(0, 9);
        pins();
        wr(0, 0);
        pins();
        wr(0, 9);
        pins();
        wr(0, 2);
        pins();
    endtask
    task automatic t_5v;
        wr(0, 0);
        wr(4, 8);
        wr(8, 8);
        pins();
        wr(8, 0);
        pins();
        wr(0, 4);
        pins();
        wr(8, 8);
        pins();
        bus(0, 8, 0);
        chk(rd, 32'h00000008);
        bus(0, 4, 0);
        chk(rd, 32'h00000008);
    endtask
    task automatic t_status;
        wr(0, 6);
        bus(0, 12, 0);
        chk(rd & 32'hf0, 32'hd0);
        wr(0, 4);
        bus(0, 12, 0);
        chk(rd & 32'hf0, 32'h40);
    endtask
    initial forever #2.5 sys_clk = ~sys_clk;
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 0;
        t_reset();
        t_regs();
        t_12v();
        t_5v();
        t_status();
        finish_test();
    end
endmodule
bind sbp_path_ctrl sbp_path_ctrl_assertions sbp_path_ctrl_assertions_inst (.*);
`default_nettype wire

// [sbp_pin_cell.v]
// sbp_pin_cell.v: one port pin, choosing between a routed path and the general port latch
// assumes pin drivers outside resolve the three signals into a wire
`timescale 1ns/1ps
`default_nettype none

module sbp_pin_cell (
    // path side
    input  wire path_sel,
    input  wire path_out,
    input  wire path_oe,
    // general port latch side
    input  wire gpio_out,
    input  wire gpio_oe,
    // pin
    output wire pin_o,
    output wire pin_oe
);

    assign pin_o  = path_sel ? path_out : gpio_out;
    assign pin_oe = path_sel ? path_oe  : gpio_oe;

endmodule

`default_nettype wire

// [sbp_wb_slave.v]
// sbp_wb_slave.v: classic wishbone single cycle handshake, one wait state then ack
// assumes a master that holds its request until ack is seen
`timescale 1ns/1ps
`default_nettype none

module sbp_wb_slave (
    // clock and reset
    input  wire sys_clk,
    input  wire rst,
    // bus request
    input  wire wb_cyc_i,
    input  wire wb_stb_i,
    input  wire wb_we_i,
    // outputs
    output wire wb_ack_o,
    output wire wr_go,
    output wire rd_go
);

    reg ack_r;
    wire req;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;

    always @(posedge sys_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // strobes fire on the cycle before ack so data is ready with it
    assign wb_ack_o = ack_r;
    assign wr_go    = req & wb_we_i;
    assign rd_go    = req & ~wb_we_i;

endmodule

`default_nettype wire
